//--- hw/shreg_pkg.sv
// constants, register map and bus state type of the four-bit shift/load register
// Functional notes
// - Four edge-triggered stages hold the state, each fed from its parallel input or the stage before (stage 0 from serial_in).
// - The stages change only on a falling edge of shift_clock_n, never on a rising one.
// - With load_shift_select high at the edge, parallel_inputs 0..3 load stages 0..3 and serial_in is ignored.
// - With load_shift_select low at the edge, stage 0 moves to 1, 1 to 2 and 2 to 3.
// - During a shift stage 0 takes serial_in and parallel_inputs are ignored.
// - While clear_n is low all four stages are forced low at once, overriding every clocked action.
// - With out_drive_enable_n high the stage outputs float, with it low they drive the stored stages.
// - Floating the outputs does not stop shifting, loading or clearing of the stages.
// - cascade_output always drives the last stage, whatever out_drive_enable_n does.
package shreg_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] SNAP_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS = 4'hc;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_SNAP_EN_BIT = 0;
  localparam int STAT_STAGE_LSB = 0;
  localparam int STAT_VALID_BIT = 4;
  localparam int STAT_OVF_BIT = 5;
  localparam int STAT_MODE_BIT = 6;
  localparam int STAT_CLEAR_BIT = 7;
  localparam int SNAP_VALID_BIT = 8;
  localparam int COUNT_SHIFT_LSB = 16;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int STAGE_W = 4;
  localparam int SNAP_DEPTH = 2;
  localparam int CNT_W = 16;
  localparam logic [STAGE_W-1:0] STAGE_RST = 4'h0;
  localparam logic CTRL_SNAP_EN_RST = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // bus answer state, one wait state per access
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage

//--- hw/rst_sync.sv
// two-stage release synchroniser for the active-low reset
`timescale 1ns/10ps
`default_nettype none
module rst_sync (
  input wire logic i_clock,
  input wire logic i_nrst,
  output logic o_nrst
);
  logic meta_r;
  logic hold_r;

  // assert at once, release after two edges so no flop sees a ragged release
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      hold_r <= meta_r;
    end
  end

  assign o_nrst = hold_r;
endmodule
`default_nettype wire

//--- hw/snap_fifo.sv
// small valid/ready buffer holding stage snapshots
`timescale 1ns/10ps
`default_nettype none
module snap_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign o_in_ready = (count_r != FULL_CNT);
  assign o_out_valid = (count_r != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r];

  // storage needs no reset; valid gating hides stale words
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers wrap at the depth, count tracks simultaneous push and pop
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/shift_load_register.sv
// four-bit shift/parallel-load register with tristate outputs and avalon register port
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module shift_load_register
  import shreg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  // device pins; shift clock, mode and data sampled on i_clock, clear and output enable act directly
  input wire logic i_shift_clock_n,
  input wire logic i_clear_n,
  input wire logic i_load_shift_select,
  input wire logic i_serial_in,
  input wire logic [STAGE_W-1:0] i_parallel_inputs,
  input wire logic i_out_drive_enable_n,
  output logic [STAGE_W-1:0] o_stage_outputs,
  output logic [STAGE_W-1:0] o_stage_outputs_oe,
  output logic o_cascade_output,
  // snapshot buffer has room; board should hold the clock while low
  output logic o_snap_ready,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // ---------------------------------------------------------------
  // reset
  // ---------------------------------------------------------------
  logic rst_n;
  logic stage_clr_n;

  rst_sync u_rst_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .o_nrst(rst_n)
  );

  // pin clear acts without the clock, as does reset; both reach only constants
  assign stage_clr_n = rst_n & i_clear_n;

  // ---------------------------------------------------------------
  // active edge detection
  // ---------------------------------------------------------------
  logic shift_clk_prev_r;
  logic active_edge;

  // history starts low so a pin already low at release is not an edge
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_clk_prev_r <= 1'b0;
    end else begin
      shift_clk_prev_r <= i_shift_clock_n;
    end
  end

  // only high-to-low counts; rising transitions are simply ignored
  assign active_edge = shift_clk_prev_r & ~i_shift_clock_n;

  // ---------------------------------------------------------------
  // stage storage
  // ---------------------------------------------------------------
  logic [STAGE_W-1:0] stage_r;
  logic [STAGE_W-1:0] stage_nxt;

  // mode picks the d input of every stage together
  always_comb begin
    if (i_load_shift_select) begin
      stage_nxt = i_parallel_inputs;
    end else begin
      stage_nxt = {stage_r[STAGE_W-2:0], i_serial_in};
    end
  end

  // mode, serial and parallel pins are trusted stable at the edge sample
  always_ff @(posedge i_clock or negedge stage_clr_n) begin
    if (!stage_clr_n) begin
      stage_r <= STAGE_RST;
    end else if (active_edge) begin
      stage_r <= stage_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  // enable only gates the drivers; the stages above keep running
  assign o_stage_outputs = stage_r;
  assign o_stage_outputs_oe = {STAGE_W{~i_out_drive_enable_n}};
  assign o_cascade_output = stage_r[STAGE_W-1];

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  bus_state_t bus_state_r;
  logic bus_req;
  logic bus_accept;
  logic wr_accept;
  logic rd_accept;
  logic snap_en_r;

  assign bus_req = i_avs_read | i_avs_write;
  assign bus_accept = bus_req & (bus_state_r == BUS_ANSWER);
  assign wr_accept = bus_accept & i_avs_write;
  assign rd_accept = bus_accept & i_avs_read;

  // byte lane 0 carries the snapshot enable
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_en_r <= CTRL_SNAP_EN_RST;
    end else if (wr_accept && i_avs_address == CTRL_OFS && i_avs_byteenable[0]) begin
      snap_en_r <= i_avs_writedata[CTRL_SNAP_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // snapshot buffer
  // ---------------------------------------------------------------
  logic snap_push;
  logic snap_in_ready;
  logic snap_valid;
  logic snap_pop;
  logic [STAGE_W-1:0] snap_data;

  // each clocked update is offered while software wants snapshots
  assign snap_push = active_edge & stage_clr_n & snap_en_r;
  assign snap_pop = rd_accept & (i_avs_address == SNAP_OFS);
  assign o_snap_ready = snap_in_ready;

  snap_fifo #(
    .WIDTH(STAGE_W),
    .DEPTH(SNAP_DEPTH)
  ) u_snap_fifo (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_in_valid(snap_push),
    .o_in_ready(snap_in_ready),
    .i_in_data(stage_nxt),
    .o_out_valid(snap_valid),
    .i_out_ready(snap_pop),
    .o_out_data(snap_data)
  );

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic ovf_r;
  logic last_mode_r;
  logic clear_seen_r;
  logic ovf_clr;
  logic clear_seen_clr;

  // write-one-to-clear on the status word
  assign ovf_clr = wr_accept && i_avs_address == STATUS_OFS && i_avs_byteenable[0]
    && i_avs_writedata[STAT_OVF_BIT];
  assign clear_seen_clr = wr_accept && i_avs_address == STATUS_OFS && i_avs_byteenable[0]
    && i_avs_writedata[STAT_CLEAR_BIT];

  // a dropped snapshot is sticky; a new drop wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= 1'b0;
    end else if (snap_push && !snap_in_ready) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // clear pin seen low at least once; held clear keeps setting it
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_seen_r <= 1'b0;
    end else if (!i_clear_n) begin
      clear_seen_r <= 1'b1;
    end else if (clear_seen_clr) begin
      clear_seen_r <= 1'b0;
    end
  end

  // mode used at the most recent edge, one means parallel load
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      last_mode_r <= 1'b0;
    end else if (active_edge && i_clear_n) begin
      last_mode_r <= i_load_shift_select;
    end
  end

  // ---------------------------------------------------------------
  // edge counters
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] load_cnt_r;
  logic [CNT_W-1:0] shift_cnt_r;
  logic cnt_clr;
  logic count_load;
  logic count_shift;

  // edges swallowed by an active clear change nothing and are not counted
  assign count_load = active_edge & i_clear_n & i_load_shift_select;
  assign count_shift = active_edge & i_clear_n & ~i_load_shift_select;
  assign cnt_clr = wr_accept & (i_avs_address == COUNT_OFS);

  // a write to the count word zeroes both; an edge in that cycle still counts as one
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      load_cnt_r <= CNT_RST;
      shift_cnt_r <= CNT_RST;
    end else if (cnt_clr) begin
      load_cnt_r <= {{(CNT_W-1){1'b0}}, count_load};
      shift_cnt_r <= {{(CNT_W-1){1'b0}}, count_shift};
    end else begin
      if (count_load) begin
        load_cnt_r <= load_cnt_r + 1'b1;
      end
      if (count_shift) begin
        shift_cnt_r <= shift_cnt_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // every access waits one cycle so read data can come from a flop
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      unique case (bus_state_r)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  assign o_avs_waitrequest = bus_req & (bus_state_r == BUS_IDLE);

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_avs_address)
      CTRL_OFS: begin
        rdata_nxt[CTRL_SNAP_EN_BIT] = snap_en_r;
      end
      STATUS_OFS: begin
        rdata_nxt[STAT_STAGE_LSB +: STAGE_W] = stage_r;
        rdata_nxt[STAT_VALID_BIT] = snap_valid;
        rdata_nxt[STAT_OVF_BIT] = ovf_r;
        rdata_nxt[STAT_MODE_BIT] = last_mode_r;
        rdata_nxt[STAT_CLEAR_BIT] = clear_seen_r;
      end
      SNAP_OFS: begin
        rdata_nxt[STAGE_W-1:0] = snap_valid ? snap_data : STAGE_RST;
        rdata_nxt[SNAP_VALID_BIT] = snap_valid;
      end
      COUNT_OFS: begin
        rdata_nxt[CNT_W-1:0] = load_cnt_r;
        rdata_nxt[COUNT_SHIFT_LSB +: CNT_W] = shift_cnt_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // captured in the wait cycle; the buffer head cannot move before the pop
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_avs_read && bus_state_r == BUS_IDLE) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

endmodule
`default_nettype wire

//--- tb/shift_load_register_properties.sv
// concurrent properties on the pins of the four-bit shift/load register
`timescale 1ns/10ps
`default_nettype none
module shift_load_register_properties
  import shreg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_shift_clock_n,
  input wire logic i_clear_n,
  input wire logic i_load_shift_select,
  input wire logic i_serial_in,
  input wire logic [STAGE_W-1:0] i_parallel_inputs,
  input wire logic i_out_drive_enable_n,
  input wire logic [STAGE_W-1:0] o_stage_outputs,
  input wire logic [STAGE_W-1:0] o_stage_outputs_oe,
  input wire logic o_cascade_output
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // ---------------------------------------------------------------
  // falling pin edge as sampled on the system clock
  // ---------------------------------------------------------------
  logic sck_r;
  logic fall;
  // starts high so a pin held low through reset counts as an edge at the first sample after release
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) sck_r <= 1'b1;
    else sck_r <= i_shift_clock_n;
  end
  assign fall = sck_r && !i_shift_clock_n && i_clear_n;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  chk_oe_follows:
    assert property (o_stage_outputs_oe == {STAGE_W{~i_out_drive_enable_n}})
    else $error("output enables do not follow the enable pin");
  chk_cascade_tracks:
    assert property (o_cascade_output == o_stage_outputs[STAGE_W-1])
    else $error("cascade output differs from last stage");
  chk_clear_zeroes:
    assert property (!i_clear_n |-> o_stage_outputs == '0 && !o_cascade_output)
    else $error("stages not zero while cleared");
  chk_load_takes_par:
    assert property (fall && i_load_shift_select |=>
      !i_clear_n || o_stage_outputs == $past(i_parallel_inputs))
    else $error("parallel load wrong");
  chk_shift_right:
    assert property (fall && !i_load_shift_select |=>
      !i_clear_n || o_stage_outputs == {$past(o_stage_outputs[2:0]), $past(i_serial_in)})
    else $error("right shift wrong");
  chk_hold_no_fall:
    assert property (!fall && i_clear_n |=> !i_clear_n || $stable(o_stage_outputs))
    else $error("stages changed without a falling edge");
  chk_load_while_float:
    assert property (fall && i_out_drive_enable_n && i_load_shift_select |=>
      !i_clear_n || (o_stage_outputs == $past(i_parallel_inputs) && o_stage_outputs_oe == '0))
    else $error("load lost while outputs floated");
  chk_reset_zero:
    assert property ($rose(i_nrst) |-> o_stage_outputs == '0 ##1 o_stage_outputs == '0)
    else $error("stages not zero after reset");

  cover property (fall && i_load_shift_select);
  cover property (fall && !i_load_shift_select);
  cover property (!i_clear_n);
endmodule
bind shift_load_register shift_load_register_properties chk_u (
  .i_clock(i_clock),
  .i_nrst(i_nrst),
  .i_shift_clock_n(i_shift_clock_n),
  .i_clear_n(i_clear_n),
  .i_load_shift_select(i_load_shift_select),
  .i_serial_in(i_serial_in),
  .i_parallel_inputs(i_parallel_inputs),
  .i_out_drive_enable_n(i_out_drive_enable_n),
  .o_stage_outputs(o_stage_outputs),
  .o_stage_outputs_oe(o_stage_outputs_oe),
  .o_cascade_output(o_cascade_output)
);
`default_nettype wire

//--- tb/shreg_board_model.sv
// board logic that clocks the register and feeds mode and data
`timescale 1ns/10ps
`default_nettype none
module shreg_board_model
  import shreg_pkg::*;
(
  input wire logic i_clock,
  input wire logic [STAGE_W-1:0] i_stage_outputs,
  output logic o_shift_clock_n,
  output logic o_load_shift_select,
  output logic o_serial_in,
  output logic [STAGE_W-1:0] o_parallel_inputs
);
  initial begin
    o_shift_clock_n = 1'b1;
    o_load_shift_select = 1'b0;
    o_serial_in = 1'b0;
    o_parallel_inputs = 4'h0;
  end

  // one falling pin edge; low_cycles > 1 gives a slow board
  task automatic clock_once(input logic sel, input logic ser,
                            input logic [STAGE_W-1:0] par, input int low_cycles);
    @(posedge i_clock);
    o_load_shift_select <= sel;
    o_serial_in <= ser;
    o_parallel_inputs <= par;
    o_shift_clock_n <= 1'b0;
    repeat (low_cycles) @(posedge i_clock);
    o_shift_clock_n <= 1'b1;
    // data turns over once the edge is past, so stale values are never trusted
    o_serial_in <= ~ser;
    o_parallel_inputs <= ~par;
  endtask

  // left shift: stages 3,2,1 wired back to parallel 2,1,0, link bit on parallel 3
  task automatic left_once(input logic link);
    clock_once(1'b1, 1'b0, {link, i_stage_outputs[3:1]}, 1);
  endtask
endmodule
`default_nettype wire

//--- tb/shift_load_register_tb_top.sv
// self-checking bench for the four-bit shift/load register
`timescale 1ns/10ps
`default_nettype none
module shift_load_register_tb_top;
  import shreg_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic clear_n = 1'b1;
  logic oe_n = 1'b0;
  logic sck_n, sel, ser, cascade, snap_ready, wait_req;
  logic [STAGE_W-1:0] par, stage, stage_oe;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic [STAGE_W-1:0] exp_stage = 4'h0;
  int num_errors = 0;
  int samples_checked = 0;

  always #4 i_clock = ~i_clock;

  shift_load_register dut_u (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_shift_clock_n(sck_n), .i_clear_n(clear_n),
    .i_load_shift_select(sel), .i_serial_in(ser), .i_parallel_inputs(par),
    .i_out_drive_enable_n(oe_n), .o_stage_outputs(stage), .o_stage_outputs_oe(stage_oe),
    .o_cascade_output(cascade), .o_snap_ready(snap_ready), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(readdata), .o_avs_waitrequest(wait_req)
  );
  shreg_board_model board_u (
    .i_clock(i_clock), .i_stage_outputs(stage), .o_shift_clock_n(sck_n),
    .o_load_shift_select(sel), .o_serial_in(ser), .o_parallel_inputs(par)
  );

  // ---------------------------------------------------------------
  // verdict, comparisons and bus cycles
  // ---------------------------------------------------------------
  task automatic complete_run;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // pins as {cascade, enables, stages}, looked at once the edge has settled
  task automatic cmp_pins(input logic [8:0] want);
    @(negedge i_clock);
    cmp_word({23'h0, cascade, stage_oe, stage}, {23'h0, want});
  endtask

  function automatic logic [8:0] pins(input logic [3:0] s);
    return {s[3], {4{~oe_n}}, s};
  endfunction

  // request holds until the rising edge that samples waitrequest low; data taken there
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge i_clock);
    end while (wait_req !== 1'b0);
    rd = readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic av_read_chk(input logic [3:0] a, input logic [31:0] want);
    av_xfer(1'b0, a, 32'h0);
    cmp_word(rd, want);
  endtask

  // kind 0 loads, 1 shifts right, 2 shifts left through the board wiring
  task automatic step(input int kind, input logic b, input logic [3:0] p, input int low);
    case (kind)
      0: begin
        board_u.clock_once(1'b1, b, p, low);
        exp_stage = p;
      end
      1: begin
        board_u.clock_once(1'b0, b, p, low);
        exp_stage = {exp_stage[2:0], b};
      end
      default: begin
        board_u.left_once(b);
        exp_stage = {b, exp_stage[3:1]};
      end
    endcase
    cmp_pins(pins(exp_stage));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clock);
    cmp_pins(pins(4'h0));
    step(0, 1'b1, 4'h5, 1);
    step(1, 1'b1, 4'ha, 3);
    cmp_word({31'h0, snap_ready}, 32'h0);
    av_read_chk(SNAP_OFS, 32'h105);
    av_read_chk(SNAP_OFS, 32'h10b);
    av_read_chk(SNAP_OFS, 32'h0);
    @(negedge i_clock);
    cmp_word({31'h0, snap_ready}, 32'h1);
    av_read_chk(4'h2, 32'h0);
    av_xfer(1'b1, CTRL_OFS, 32'h0);
    av_xfer(1'b1, COUNT_OFS, 32'h0);
    @(posedge i_clock);
    oe_n <= 1'b1;
    step(0, 1'b0, 4'h9, 1);
    @(posedge i_clock);
    oe_n <= 1'b0;
    step(1, 1'b0, 4'h0, 2);
    step(1, 1'b1, 4'hf, 1);
    step(2, 1'b1, 4'h0, 1);
    step(2, 1'b0, 4'h0, 1);
    step(0, 1'b0, 4'hf, 1);
    av_read_chk(COUNT_OFS, {16'd2, 16'd4});
    @(posedge i_clock);
    clear_n <= 1'b0;
    cmp_pins(pins(4'h0));
    board_u.clock_once(1'b1, 1'b0, 4'h7, 1);
    cmp_pins(pins(4'h0));
    @(posedge i_clock);
    clear_n <= 1'b1;
    av_xfer(1'b0, STATUS_OFS, 32'h0);
    cmp_word(rd & 32'h8f, 32'h80);
    // three snapshots into a two-deep buffer: the third is dropped and flagged
    av_xfer(1'b1, CTRL_OFS, 32'h1);
    step(0, 1'b0, 4'h1, 1);
    step(0, 1'b0, 4'h2, 1);
    step(0, 1'b0, 4'h3, 1);
    av_xfer(1'b0, STATUS_OFS, 32'h0);
    cmp_word(rd & 32'h3f, 32'h33);
    complete_run();
  end

  // the run needs about a hundred cycles; far beyond that something hangs
  initial begin
    repeat (5000) @(posedge i_clock);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
